// file: src/pdc_pkg.sv
package pdc_pkg;

  // Channel counts for the full and reduced builds
  localparam int unsigned NCH_FULL    = 9;
  localparam int unsigned NCH_REDUCED = 1;

  // Bus widths
  localparam int unsigned AW  = 32;
  localparam int unsigned DW  = 32;
  localparam int unsigned CW  = 16;
  localparam int unsigned CHW = 4;

  // Staging FIFO depth in words
  localparam int unsigned FIFO_DEPTH = 32;

  // Address step for one word beat, in bytes
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;

  // Transfer direction codes per channel
  localparam logic [1:0] MODE_P2M = 2'h0;
  localparam logic [1:0] MODE_M2P = 2'h1;
  localparam logic [1:0] MODE_M2M = 2'h2;

  // Bus master encodings
  localparam logic [1:0] TRANS_IDLE   = 2'h0;
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;
  localparam logic [2:0] SIZE_WORD    = 3'h2;
  localparam logic [2:0] BURST_SINGLE = 3'h0;
  localparam logic       RESP_OKAY    = 1'h0;

  // Reset values and the one-beat count step
  localparam logic [31:0] ADDR_RST  = 32'h0000_0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  // Engine sequencing states
  typedef enum logic [2:0] {
    PDC_IDLE,
    PDC_RD_ADDR,
    PDC_RD_DATA,
    PDC_WR_PREP,
    PDC_WR_ADDR,
    PDC_WR_DATA
  } pdc_state_e;

endpackage

// file: src/pdc_fifo.sv
`timescale 1ns/100ps
module pdc_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;

  wire push = in_valid_i & in_ready_o;
  wire pop  = out_valid_o & out_ready_i;

  // Full and empty flags from the fill count
  assign in_ready_o  = (count != (PW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  // Storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule

// file: src/pdc_top.sv
// Functional notes
// - Nine one-way channels, three direction modes
// - Each channel stages one word before writing
// - Cleared enable stops new beats for channel
// - Completion sets pollable status and interrupt
// - Source and destination increment or fixed
// - Fixed priority, channel 0 highest, 8 lowest
// - Bus master moves data, input ports program channels
// - Reduced build keeps only channel 0
`timescale 1ns/100ps
module pdc_top #(
  parameter bit REDUCED = 1'b0
) (
  input  wire logic         REF_CLK_I,
  input  wire logic         RST_I,
  input  wire logic [8:0]   CH_START_I,
  input  wire logic [8:0]   CH_EN_I,
  input  wire logic [17:0]  CH_MODE_I,
  input  wire logic [8:0]   CH_SRC_INC_I,
  input  wire logic [8:0]   CH_DST_INC_I,
  input  wire logic [287:0] CH_SRC_ADDR_I,
  input  wire logic [287:0] CH_DST_ADDR_I,
  input  wire logic [143:0] CH_COUNT_I,
  input  wire logic [8:0]   CH_PREQ_I,
  input  wire logic [8:0]   CH_DONE_CLR_I,
  output logic      [8:0]   CH_ACK_O,
  output logic      [8:0]   CH_BUSY_O,
  output logic      [8:0]   CH_DONE_O,
  output logic      [8:0]   CH_ERR_O,
  output logic              IRQ_O,
  output logic      [1:0]   HTRANS_O,
  output logic      [31:0]  HADDR_O,
  output logic              HWRITE_O,
  output logic      [2:0]   HSIZE_O,
  output logic      [2:0]   HBURST_O,
  output logic      [31:0]  HWDATA_O,
  input  wire logic [31:0]  HRDATA_I,
  input  wire logic         HREADY_I,
  input  wire logic         HRESP_I
);

  localparam int unsigned NCH = pdc_pkg::NCH_FULL;
  localparam int unsigned NUSE = REDUCED ? pdc_pkg::NCH_REDUCED : pdc_pkg::NCH_FULL;

  pdc_pkg::pdc_state_e state;
  logic [pdc_pkg::CHW-1:0] act;
  logic [31:0]             src_addr [NCH];
  logic [31:0]             dst_addr [NCH];
  logic [15:0]             remain   [NCH];
  logic [31:0]             stage    [NCH];
  logic [8:0]              present;
  logic [8:0]              ready;
  logic [pdc_pkg::CHW-1:0] pick;
  logic                    pick_ok;

  // Channels present in this build
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      present[i] = (i < NUSE);
    end
  end

  // Channel may start a beat: busy, enabled, paced by peripheral if any
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      ready[i] = present[i] & CH_BUSY_O[i] & CH_EN_I[i]
               & ((CH_MODE_I[2*i +: 2] == pdc_pkg::MODE_M2M)
                  | ((CH_MODE_I[2*i +: 2] != 2'h3) & CH_PREQ_I[i]));
    end
  end

  // Fixed priority pick, lowest index wins
  always_comb begin
    pick    = '0;
    pick_ok = 1'b0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (ready[i]) begin
        pick    = pdc_pkg::CHW'(i);
        pick_ok = 1'b1;
      end
    end
  end

  // Staging FIFO between read and write phases
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [31:0] fifo_out_data;
  // Only a good read response may stage a word; a failed read leaves nothing behind
  wire         fifo_push = (state == pdc_pkg::PDC_RD_DATA) & HREADY_I
                           & (HRESP_I == pdc_pkg::RESP_OKAY);
  wire         fifo_pop  = (state == pdc_pkg::PDC_WR_PREP) & fifo_out_valid;

  pdc_fifo #(
    .WIDTH (pdc_pkg::DW),
    .DEPTH (pdc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (REF_CLK_I),
    .rst_i       (RST_I),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (HRDATA_I),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out_data)
  );

  // Beat completion decode for the active channel
  wire         beat_ok   = (state == pdc_pkg::PDC_WR_DATA) & HREADY_I
                           & (HRESP_I == pdc_pkg::RESP_OKAY);
  wire         rd_err    = (state == pdc_pkg::PDC_RD_DATA) & HREADY_I
                           & (HRESP_I != pdc_pkg::RESP_OKAY);
  wire         wr_err    = (state == pdc_pkg::PDC_WR_DATA) & HREADY_I
                           & (HRESP_I != pdc_pkg::RESP_OKAY);
  wire         last_beat = (remain[act] == pdc_pkg::COUNT_ONE);
  wire [31:0]  next_src  = src_addr[act] + pdc_pkg::WORD_BYTES;
  wire [31:0]  next_dst  = dst_addr[act] + pdc_pkg::WORD_BYTES;
  wire         start_go  = pick_ok & fifo_in_ready;

  logic [8:0] next_done;
  logic [8:0] done_set;

  // Completion events per channel
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      done_set[i] = beat_ok & last_beat & (act == pdc_pkg::CHW'(i));
    end
    next_done = (CH_DONE_O & ~CH_DONE_CLR_I) | done_set;
  end

  // Bus master sequencing, one single beat at a time
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state    <= pdc_pkg::PDC_IDLE;
      act      <= '0;
      HTRANS_O <= pdc_pkg::TRANS_IDLE;
      HADDR_O  <= pdc_pkg::ADDR_RST;
      HWRITE_O <= 1'b0;
      HWDATA_O <= '0;
    end else begin
      unique case (state)
        pdc_pkg::PDC_IDLE: begin
          if (start_go) begin
            act      <= pick;
            HADDR_O  <= src_addr[pick];
            HWRITE_O <= 1'b0;
            HTRANS_O <= pdc_pkg::TRANS_NONSEQ;
            state    <= pdc_pkg::PDC_RD_ADDR;
          end
        end
        pdc_pkg::PDC_RD_ADDR: begin
          if (HREADY_I) begin
            HTRANS_O <= pdc_pkg::TRANS_IDLE;
            state    <= pdc_pkg::PDC_RD_DATA;
          end
        end
        pdc_pkg::PDC_RD_DATA: begin
          if (HREADY_I) begin
            state <= rd_err ? pdc_pkg::PDC_IDLE : pdc_pkg::PDC_WR_PREP;
          end
        end
        pdc_pkg::PDC_WR_PREP: begin
          if (fifo_out_valid) begin
            HADDR_O  <= dst_addr[act];
            HWRITE_O <= 1'b1;
            HTRANS_O <= pdc_pkg::TRANS_NONSEQ;
            state    <= pdc_pkg::PDC_WR_ADDR;
          end
        end
        pdc_pkg::PDC_WR_ADDR: begin
          if (HREADY_I) begin
            HTRANS_O <= pdc_pkg::TRANS_IDLE;
            HWDATA_O <= stage[act];
            state    <= pdc_pkg::PDC_WR_DATA;
          end
        end
        pdc_pkg::PDC_WR_DATA: begin
          if (HREADY_I) begin
            HWRITE_O <= 1'b0;
            state    <= pdc_pkg::PDC_IDLE;
          end
        end
        default: begin
          state <= pdc_pkg::PDC_IDLE;
        end
      endcase
    end
  end

  // Constant transfer attributes
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      HSIZE_O  <= pdc_pkg::SIZE_WORD;
      HBURST_O <= pdc_pkg::BURST_SINGLE;
    end else begin
      HSIZE_O  <= pdc_pkg::SIZE_WORD;
      HBURST_O <= pdc_pkg::BURST_SINGLE;
    end
  end

  // Per-channel context: load on start, advance on each good beat
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      CH_BUSY_O <= '0;
      CH_ERR_O  <= '0;
      CH_ACK_O  <= '0;
      for (int i = 0; i < NCH; i++) begin
        src_addr[i] <= pdc_pkg::ADDR_RST;
        dst_addr[i] <= pdc_pkg::ADDR_RST;
        remain[i]   <= pdc_pkg::COUNT_RST;
        stage[i]    <= '0;
      end
    end else begin
      CH_ACK_O <= '0;
      for (int i = 0; i < NCH; i++) begin
        if (CH_START_I[i] & present[i] & ~CH_BUSY_O[i]
            & (CH_COUNT_I[16*i +: 16] != pdc_pkg::COUNT_RST)) begin
          src_addr[i]  <= CH_SRC_ADDR_I[32*i +: 32];
          dst_addr[i]  <= CH_DST_ADDR_I[32*i +: 32];
          remain[i]    <= CH_COUNT_I[16*i +: 16];
          CH_BUSY_O[i] <= 1'b1;
          CH_ERR_O[i]  <= 1'b0;
        end
      end
      if (fifo_pop) begin
        stage[act] <= fifo_out_data;
      end
      if (beat_ok) begin
        if (CH_SRC_INC_I[act]) begin
          src_addr[act] <= next_src;
        end
        if (CH_DST_INC_I[act]) begin
          dst_addr[act] <= next_dst;
        end
        remain[act]   <= remain[act] - pdc_pkg::COUNT_ONE;
        CH_ACK_O[act] <= 1'b1;
        if (last_beat) begin
          CH_BUSY_O[act] <= 1'b0;
        end
      end
      if (rd_err | wr_err) begin
        CH_BUSY_O[act] <= 1'b0;
        CH_ERR_O[act]  <= 1'b1;
      end
    end
  end

  // Sticky completion status and interrupt request
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      CH_DONE_O <= '0;
      IRQ_O     <= 1'b0;
    end else begin
      CH_DONE_O <= next_done;
      IRQ_O     <= |next_done;
    end
  end

endmodule

// file: sim/pdc_properties.sv
`timescale 1ns/100ps
module pdc_properties (
  input wire logic         REF_CLK_I,
  input wire logic         RST_I,
  input wire logic [8:0]   CH_START_I,
  input wire logic [8:0]   CH_EN_I,
  input wire logic [143:0] CH_COUNT_I,
  input wire logic [8:0]   CH_ACK_O,
  input wire logic [8:0]   CH_BUSY_O,
  input wire logic [8:0]   CH_DONE_O,
  input wire logic [8:0]   CH_ERR_O,
  input wire logic         IRQ_O,
  input wire logic [1:0]   HTRANS_O,
  input wire logic         HWRITE_O,
  input wire logic [2:0]   HSIZE_O,
  input wire logic [2:0]   HBURST_O,
  input wire logic         HREADY_I
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // Zero-wait read beat: address phase, data phase, staging cycle
  sequence rd_beat;
    HTRANS_O == pdc_pkg::TRANS_NONSEQ && !HWRITE_O && HREADY_I ##1 HREADY_I [*2];
  endsequence
  // Zero-wait write beat: address phase then data phase
  sequence wr_beat;
    HTRANS_O == pdc_pkg::TRANS_NONSEQ && HWRITE_O && HREADY_I ##1 HREADY_I;
  endsequence
  size_word_a: assert property (HSIZE_O == pdc_pkg::SIZE_WORD)
    else $error("size not word");
  burst_single_a: assert property (HBURST_O == pdc_pkg::BURST_SINGLE)
    else $error("burst not single");
  one_nonseq_a: assert property (HTRANS_O == pdc_pkg::TRANS_NONSEQ && HREADY_I
    |=> HTRANS_O == pdc_pkg::TRANS_IDLE) else $error("second beat in flight");
  start_busy_a: assert property (CH_START_I[0] && !CH_BUSY_O[0] && CH_COUNT_I[15:0] != 0
    |=> CH_BUSY_O[0]) else $error("start not taken");
  read_write_a: assert property (rd_beat |=> HTRANS_O == pdc_pkg::TRANS_NONSEQ && HWRITE_O)
    else $error("staged word not written");
  write_ack_a: assert property (wr_beat |=> CH_ACK_O != 9'h000)
    else $error("write without ack");
  done_flag_a: assert property (!$past(RST_I) && $fell(CH_BUSY_O[0]) && !CH_ERR_O[0]
    |-> CH_DONE_O[0]) else $error("end without done");
  irq_done_a: assert property (IRQ_O == (|CH_DONE_O))
    else $error("irq not done or");
  last_irq_a: assert property (CH_ACK_O[0] && !CH_BUSY_O[0] |-> IRQ_O && CH_DONE_O[0])
    else $error("last beat without irq");
  halt_beat_a: assert property ((CH_EN_I & CH_BUSY_O) == 9'h000
    |=> !(HTRANS_O == pdc_pkg::TRANS_NONSEQ && !HWRITE_O)) else $error("beat while halted");
endmodule
bind pdc_top pdc_properties chk (.*);

// file: sim/pdc_mem.sv
`timescale 1ns/100ps
module pdc_mem (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        slow_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic        hwrite_i,
  input  wire logic [31:0] hwdata_i,
  output logic      [31:0] hrdata_o,
  output logic             hready_o,
  output logic             hresp_o
);
  logic [31:0] m [64];
  logic [5:0]  a;
  logic        ph;
  logic        wr;
  logic        wt;
  // Known pattern in every word
  initial for (int i = 0; i < 64; i++) m[i] = {16'ha5a5, 16'(i)};
  // Address capture, optional single wait state, write at data phase end
  always @(posedge clk_i) begin
    if (rst_i) begin
      ph <= 1'b0;
    end else if (hready_o) begin
      ph <= htrans_i == pdc_pkg::TRANS_NONSEQ;
      a <= haddr_i[7:2];
      wr <= hwrite_i;
      wt <= slow_i;
    end else begin
      wt <= 1'b0;
    end
    if (ph && hready_o && wr) m[a] <= hwdata_i;
  end
  // Read data only in read data phase, inverted otherwise
  assign hready_o = !(ph && wt);
  assign hresp_o  = pdc_pkg::RESP_OKAY;
  assign hrdata_o = (ph && !wr) ? m[a] : ~m[a];
endmodule

// file: sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic         REF_CLK_I, RST_I, HWRITE_O, HREADY_I, HRESP_I, IRQ_O, slow;
  logic [8:0]   CH_START_I, CH_EN_I, CH_SRC_INC_I, CH_DST_INC_I, CH_PREQ_I, CH_DONE_CLR_I;
  logic [8:0]   CH_ACK_O, CH_BUSY_O, CH_DONE_O, CH_ERR_O;
  logic [17:0]  CH_MODE_I;
  logic [287:0] CH_SRC_ADDR_I, CH_DST_ADDR_I;
  logic [143:0] CH_COUNT_I;
  logic [1:0]   HTRANS_O;
  logic [2:0]   HSIZE_O, HBURST_O;
  logic [31:0]  HADDR_O, HWDATA_O, HRDATA_I;
  int           n_fail, cmp_count, cyc, acks;
  typedef struct {int c; logic [1:0] md; bit si; bit di; bit sl; int n; int s; int d;} pdc_row_s;
  // Channel, mode, increments, wait state, count, source and destination word
  pdc_row_s rows [5] = '{
    '{0, pdc_pkg::MODE_M2M, 1, 1, 0, 3, 0, 32},
    '{4, pdc_pkg::MODE_P2M, 0, 1, 0, 2, 4, 36},
    '{7, pdc_pkg::MODE_M2P, 1, 0, 1, 3, 8, 40},
    '{8, pdc_pkg::MODE_M2M, 1, 1, 1, 1, 15, 44},
    '{2, pdc_pkg::MODE_M2M, 0, 0, 0, 2, 6, 46}};
  pdc_top uut (.*);
  pdc_mem mem (.clk_i(REF_CLK_I), .rst_i(RST_I), .slow_i(slow), .htrans_i(HTRANS_O),
    .haddr_i(HADDR_O), .hwrite_i(HWRITE_O), .hwdata_i(HWDATA_O), .hrdata_o(HRDATA_I),
    .hready_o(HREADY_I), .hresp_o(HRESP_I));
  // Clock
  initial begin
    REF_CLK_I = 1'b0;
    forever #12.5 REF_CLK_I = ~REF_CLK_I;
  end
  // Cycle ceiling and ack counting
  always @(posedge REF_CLK_I) begin
    cyc++;
    acks += $countones(CH_ACK_O);
    if (cyc == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] pat(int i);
    return {16'ha5a5, 16'(i)};
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic setup(int c, logic [1:0] md, bit si, bit di, int n, int s, int d);
    CH_MODE_I[2*c+:2] = md;
    CH_SRC_INC_I[c] = si;
    CH_DST_INC_I[c] = di;
    CH_COUNT_I[16*c+:16] = 16'(n);
    CH_SRC_ADDR_I[32*c+:32] = 32'(s * 4);
    CH_DST_ADDR_I[32*c+:32] = 32'(d * 4);
  endtask
  task automatic kick(logic [8:0] m);
    @(negedge REF_CLK_I);
    CH_START_I = m;
    @(negedge REF_CLK_I);
    CH_START_I = 9'h000;
  endtask
  task automatic drain();
    repeat (300) if (CH_BUSY_O !== 9'h000) @(negedge REF_CLK_I);
    @(negedge REF_CLK_I);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    {CH_START_I, CH_EN_I, CH_SRC_INC_I, CH_DST_INC_I, CH_DONE_CLR_I, CH_MODE_I} = '0;
    {CH_SRC_ADDR_I, CH_DST_ADDR_I, CH_COUNT_I} = '0;
    CH_PREQ_I = 9'h1ff;
    slow = 1'b0;
    RST_I = 1'b1;
    repeat (8) @(negedge REF_CLK_I);
    chk({IRQ_O, CH_BUSY_O, CH_DONE_O, HTRANS_O, HSIZE_O}, {21'h0, pdc_pkg::SIZE_WORD});
    RST_I = 1'b0;
    CH_EN_I = 9'h1ff;
    foreach (rows[i]) begin
      slow = rows[i].sl;
      setup(rows[i].c, rows[i].md, rows[i].si, rows[i].di, rows[i].n, rows[i].s, rows[i].d);
      acks = 0;
      kick(9'h001 << rows[i].c);
      drain();
      chk(acks, rows[i].n);
      chk({CH_DONE_O[rows[i].c], IRQ_O}, 2'h3);
      for (int k = 0; k < rows[i].n; k++)
        if (rows[i].di || k == rows[i].n - 1)
          chk(mem.m[rows[i].d + (rows[i].di ? k : 0)], pat(rows[i].s + (rows[i].si ? k : 0)));
    end
    // Clearing done drops the interrupt
    CH_DONE_CLR_I = 9'h1ff;
    @(negedge REF_CLK_I);
    CH_DONE_CLR_I = 9'h000;
    chk({CH_DONE_O, IRQ_O}, 10'h000);
    // Zero count is refused
    setup(1, pdc_pkg::MODE_M2M, 1, 1, 0, 0, 50);
    kick(9'h002);
    chk(CH_BUSY_O, 9'h000);
    // Simultaneous requests, lower index served first
    setup(3, pdc_pkg::MODE_M2M, 1, 1, 2, 0, 50);
    setup(8, pdc_pkg::MODE_M2M, 1, 1, 2, 0, 54);
    kick(9'h108);
    repeat (40) if (CH_ACK_O === 9'h000) @(negedge REF_CLK_I);
    chk(CH_ACK_O, 9'h008);
    drain();
    // Disabled channel holds, then resumes
    CH_EN_I[5] = 1'b0;
    setup(5, pdc_pkg::MODE_M2M, 1, 1, 2, 4, 58);
    acks = 0;
    kick(9'h020);
    repeat (30) @(negedge REF_CLK_I);
    chk({acks[7:0], CH_BUSY_O}, {8'h00, 9'h020});
    CH_EN_I[5] = 1'b1;
    drain();
    chk(mem.m[59], pat(5));
    // Peripheral request low holds a paced channel; mode 3 never runs
    CH_PREQ_I[6] = 1'b0;
    setup(6, pdc_pkg::MODE_P2M, 1, 1, 1, 9, 61);
    setup(1, 2'h3, 1, 1, 1, 9, 62);
    acks = 0;
    kick(9'h042);
    repeat (20) @(negedge REF_CLK_I);
    chk({acks[7:0], CH_BUSY_O}, {8'h00, 9'h042});
    CH_PREQ_I[6] = 1'b1;
    repeat (20) @(negedge REF_CLK_I);
    chk({CH_DONE_O[6], CH_BUSY_O}, {1'b1, 9'h002});
    chk(mem.m[61], pat(9));
    // Reset in mid-transfer clears every channel and the bus
    setup(0, pdc_pkg::MODE_M2M, 1, 1, 4, 0, 60);
    kick(9'h001);
    repeat (3) @(negedge REF_CLK_I);
    RST_I = 1'b1;
    repeat (2) @(negedge REF_CLK_I);
    chk({IRQ_O, CH_BUSY_O, CH_DONE_O, CH_ERR_O, HTRANS_O, HWRITE_O}, 31'h0);
    RST_I = 1'b0;
    // Engine recovers after the mid-run reset
    setup(0, pdc_pkg::MODE_M2M, 1, 1, 1, 8, 60);
    acks = 0;
    kick(9'h001);
    drain();
    chk(acks, 1);
    chk(mem.m[60], pat(8));
    tally_and_finish();
  end
endmodule
